// >>> design/vis_core.sv
// vis_core: vectored interrupt system with AXI4-Lite registers and timer.
// assumes fetch/op strobes and parityErr are one-cycle pulses on clk;
// serialPin is asynchronous and is synchronised inside the timer.
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module vis_core #(
  parameter int TICK = vis_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic fetchReq,
  input wire logic [15:0] fetchPc,
  input wire logic opReq,
  input wire vis_pkg::vis_op_t opSel,
  input wire logic [15:0] opAcc,
  input wire logic parityErr,
  input wire logic serialPin,
  output logic fetchDone,
  output logic fetchTake,
  output logic fetchRestart,
  output logic pcLoad,
  output logic [15:0] pcOut,
  output logic irq
);
  logic [15:0] wake_reg;
  logic [15:0] pend_reg;
  logic [15:0] active_reg;
  logic [15:0] savedPc_reg;
  logic [15:0] tmask_reg;
  logic [15:0] tcmp_reg;
  logic [15:0] vecTable [0:vis_pkg::NUM_CHANNELS-1];
  logic [2:0] sts_reg, imask_reg;
  logic [7:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic awHeld_reg, wHeld_reg;
  logic tFire;
  logic [15:0] tCapture, tClock;

  // register bus
  logic wrEn;
  logic awHeld_next;
  logic wHeld_next;
  logic bv_next;
  logic rv_next;
  logic rdVec;
  logic [15:0] wrBits, rdWord;
  logic wrWake;
  logic wrPend;
  logic wrAct;
  logic wrPc;
  logic wrTm;
  logic wrTc;
  logic wrSts;
  logic wrIm;
  logic wrVec;
  assign wrEn = ce && awHeld_reg && wHeld_reg && !bvalid;
  assign awHeld_next = (awHeld_reg || (awvalid && awready)) && !wrEn;
  assign wHeld_next = (wHeld_reg || (wvalid && wready)) && !wrEn;
  assign bv_next = wrEn || (bvalid && !bready);
  assign rv_next = (arvalid && arready) || (rvalid && !rready);
  assign wrBits = vis_pkg::vis_merge(16'h0000, wData_reg, wStrb_reg);
  assign wrWake = wrEn && awAddr_reg == vis_pkg::ADDR_NEW_WAKEUP;
  assign wrPend = wrEn && awAddr_reg == vis_pkg::ADDR_PENDING;
  assign wrAct = wrEn && awAddr_reg == vis_pkg::ADDR_ACTIVE;
  assign wrPc = wrEn && awAddr_reg == vis_pkg::ADDR_SAVED_PC;
  assign wrTm = wrEn && awAddr_reg == vis_pkg::ADDR_TIMER_MASK;
  assign wrTc = wrEn && awAddr_reg == vis_pkg::ADDR_TIMER_COMPARE;
  assign wrSts = wrEn && awAddr_reg == vis_pkg::ADDR_IRQ_STATUS && wStrb_reg[0];
  assign wrIm = wrEn && awAddr_reg == vis_pkg::ADDR_IRQ_MASK && wStrb_reg[0];
  assign wrVec = wrEn && vis_pkg::vis_is_vec(awAddr_reg);
  assign rdVec = vis_pkg::vis_is_vec(araddr);
  assign rdWord = rdVec ? vecTable[araddr[5:2]] :
    araddr == vis_pkg::ADDR_NEW_WAKEUP ? wake_reg :
    araddr == vis_pkg::ADDR_PENDING ? pend_reg :
    araddr == vis_pkg::ADDR_ACTIVE ? active_reg :
    araddr == vis_pkg::ADDR_SAVED_PC ? savedPc_reg :
    araddr == vis_pkg::ADDR_TIMER_MASK ? tmask_reg :
    araddr == vis_pkg::ADDR_TIMER_COMPARE ? tcmp_reg :
    araddr == vis_pkg::ADDR_TIMER_CAPTURE ? tCapture :
    araddr == vis_pkg::ADDR_CLOCK_STATE ? tClock :
    araddr == vis_pkg::ADDR_IRQ_STATUS ? {13'h0000, sts_reg} :
    araddr == vis_pkg::ADDR_IRQ_MASK ? {13'h0000, imask_reg} : 16'h0000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= vis_pkg::RESP_OKAY;
    end else if (ce) begin
      awHeld_reg <= awHeld_next;
      wHeld_reg <= wHeld_next;
      awready <= !awHeld_next && !bv_next;
      wready <= !wHeld_next && !bv_next;
      bvalid <= bv_next;
      if (wrEn) bresp <= vis_pkg::vis_mapped(awAddr_reg) ? vis_pkg::RESP_OKAY
                                                         : vis_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
    end else if (ce) begin
      if (awvalid && awready) awAddr_reg <= awaddr;
      if (wvalid && wready) wData_reg <= wdata;
      if (wvalid && wready) wStrb_reg <= wstrb;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= vis_pkg::RESP_OKAY;
    end else if (ce) begin
      arready <= !rv_next;
      rvalid <= rv_next;
      if (arvalid && arready) begin
        rdata <= {16'h0000, rdWord};
        rresp <= vis_pkg::vis_mapped(araddr) ? vis_pkg::RESP_OKAY : vis_pkg::RESP_SLVERR;
      end
    end
  end

  // interrupt engine
  logic [15:0] merged;
  logic [15:0] masked;
  logic [15:0] chBit;
  logic [15:0] reqSet;
  logic [15:0] pendSet;
  logic [15:0] wakeBase;
  logic [15:0] wake_next;
  logic [15:0] pend_next;
  logic [15:0] takeVec;
  logic [3:0] ch;
  logic positive;
  logic fetchGo;
  logic take;
  logic idle;
  logic opGo;
  logic disOp;
  logic enOp;
  logic retOp;
  logic timerOp;
  logic [2:0] evt, sts_next;
  assign merged = wake_reg | pend_reg;
  assign masked = merged & active_reg & vis_pkg::CHANNEL_BITS; // see RULE2 see RULE3
  assign positive = !wake_reg[15] && wake_reg != 16'h0000;
  assign fetchGo = ce && fetchReq;
  assign take = fetchGo && positive && masked != 16'h0000; // see RULE5
  assign idle = fetchGo && positive && masked == 16'h0000;
  assign ch = vis_pkg::vis_pick(masked); // see RULE18 see RULE1
  assign chBit = 16'h0001 << ch;
  assign takeVec = vecTable[ch]; // see RULE4
  assign opGo = ce && opReq && !fetchReq;
  assign disOp = opGo && opSel == vis_pkg::OP_DISABLE;
  assign enOp = opGo && opSel == vis_pkg::OP_ENABLE;
  assign retOp = opGo && opSel == vis_pkg::OP_RETURN;
  assign timerOp = opGo && opSel == vis_pkg::OP_START_TIMER;
  // new requests are ORed in last so a same-cycle clear never loses them
  assign reqSet = (parityErr ? vis_pkg::PARITY_MASK : 16'h0000) // see RULE9
    | (tFire ? tmask_reg : 16'h0000) | (wrWake ? wrBits : 16'h0000); // see RULE8
  assign pendSet = wrPend ? wrBits : 16'h0000; // see RULE8
  assign wakeBase = take ? (wake_reg | vis_pkg::DISABLE_MASK) & ~chBit : // see RULE7
    idle ? vis_pkg::RESET_WORD : // see RULE6
    disOp ? wake_reg | vis_pkg::DISABLE_MASK : // see RULE10
    (enOp || retOp) ? (wake_reg & ~vis_pkg::DISABLE_MASK) | pend_reg : wake_reg; // see RULE11
  assign wake_next = wakeBase | reqSet;
  // pending bit of the taken channel is dropped too, else it would re-fire forever
  assign pend_next = (idle ? merged : take ? pend_reg & ~chBit : pend_reg) | pendSet; // see RULE6
  assign evt = {parityErr, tFire, take};
  assign sts_next = (sts_reg & ~(wrSts ? wData_reg[2:0] : 3'h0)) | evt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_reg <= vis_pkg::RESET_WORD;
      pend_reg <= vis_pkg::RESET_WORD;
      savedPc_reg <= vis_pkg::RESET_WORD;
    end else if (ce) begin
      wake_reg <= wake_next;
      pend_reg <= pend_next;
      if (take) savedPc_reg <= fetchPc; // see RULE7
      else if (wrPc) savedPc_reg <= vis_pkg::vis_merge(savedPc_reg, wData_reg, wStrb_reg);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_reg <= vis_pkg::RESET_WORD;
      tmask_reg <= vis_pkg::RESET_WORD;
      tcmp_reg <= vis_pkg::RESET_WORD;
      imask_reg <= 3'h0;
      sts_reg <= 3'h0;
      irq <= 1'b0;
    end else if (ce) begin
      if (wrAct) active_reg <= vis_pkg::vis_merge(active_reg, wData_reg, wStrb_reg);
      if (wrTm) tmask_reg <= vis_pkg::vis_merge(tmask_reg, wData_reg, wStrb_reg);
      if (wrTc) tcmp_reg <= vis_pkg::vis_merge(tcmp_reg, wData_reg, wStrb_reg);
      if (wrIm) imask_reg <= wData_reg[2:0];
      sts_reg <= sts_next;
      irq <= |(sts_next & (wrIm ? wData_reg[2:0] : imask_reg));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < vis_pkg::NUM_CHANNELS; i++) vecTable[i] <= vis_pkg::RESET_WORD;
    end else if (ce && wrVec) begin
      vecTable[awAddr_reg[5:2]] <= vis_pkg::vis_merge(vecTable[awAddr_reg[5:2]], wData_reg,
                                                      wStrb_reg);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fetchDone <= 1'b0;
      fetchTake <= 1'b0;
      fetchRestart <= 1'b0;
      pcLoad <= 1'b0;
      pcOut <= vis_pkg::RESET_WORD;
    end else if (ce) begin
      fetchDone <= fetchGo;
      fetchTake <= take;
      fetchRestart <= idle; // see RULE6
      pcLoad <= take || retOp;
      if (take) pcOut <= takeVec; // see RULE7
      else if (retOp) pcOut <= savedPc_reg; // see RULE12
    end
  end

  vis_timer #(.TICK(TICK)) timer (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .startReq(timerOp),
    .startAcc(opAcc),
    .compareWord(tcmp_reg),
    .serialPin(serialPin),
    .fire(tFire),
    .captureWord(tCapture),
    .clockState(tClock)
  );

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_TAKE_VECTOR: assert property ( // see RULE7
    take |=> fetchTake && pcLoad && pcOut == $past(takeVec) && savedPc_reg == $past(fetchPc))
    else $error("take did not vector");
  AST_TAKE_MASKS: assert property ( // see RULE7
    take && (reqSet & chBit) == 16'h0000
    |=> wake_reg[15] && (wake_reg & $past(chBit)) == 16'h0000)
    else $error("take left channel bit");
  AST_PRIORITY: assert property ( // see RULE18
    take |-> masked[ch] && (masked & (chBit - 16'h0001)) == 16'h0000)
    else $error("wrong channel");
  AST_IDLE_STORE: assert property ( // see RULE6
    idle && reqSet == 16'h0000 |=> wake_reg == 16'h0000
    && pend_reg == ($past(merged) | $past(pendSet)) && fetchRestart)
    else $error("idle fetch did not fold pending");
  AST_NO_ACTIVE: assert property ( // see RULE5
    fetchGo && masked == 16'h0000 |=> !fetchTake)
    else $error("interrupt without active request");
  AST_DISABLED: assert property ( // see RULE10
    fetchGo && wake_reg[15] |=> !fetchTake && !fetchRestart)
    else $error("fetch acted while disabled");
  AST_DISABLE_OP: assert property ( // see RULE10
    disOp |=> wake_reg[15])
    else $error("disable op left bit clear");
  AST_ENABLE_OP: assert property ( // see RULE11
    (enOp || retOp) && !reqSet[15] |=> !wake_reg[15]
    && (wake_reg & $past(pend_reg)) == $past(pend_reg))
    else $error("enable op wrong");
  AST_RETURN_PC: assert property ( // see RULE12
    retOp |=> pcLoad && pcOut == $past(savedPc_reg))
    else $error("return did not restore pc");
  AST_PARITY: assert property ( // see RULE9
    ce && parityErr |=> wake_reg[0])
    else $error("parity error not posted");
  AST_TIMER_POST: assert property ( // see RULE13
    ce && tFire |=> (wake_reg & $past(tmask_reg)) == $past(tmask_reg))
    else $error("timer fire not posted");
  AST_B_HOLD: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
endmodule : vis_core

// >>> design/vis_timer.sv
// vis_timer: 38 us interval timer with compare and serial-line watch modes.
// assumes serialPin is asynchronous; startReq and compareWord come from clk logic.
`timescale 1ns/1ps
module vis_timer #(
  parameter int TICK = vis_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic startReq,
  input wire logic [15:0] startAcc,
  input wire logic [15:0] compareWord,
  input wire logic serialPin,
  output logic fire,
  output logic [15:0] captureWord,
  output logic [15:0] clockState
);
  localparam int CW = $clog2(TICK + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK - 1);

  logic [CW-1:0] cnt_reg;
  logic lineMeta_reg;
  logic lineSync_reg;
  logic tick;
  logic [1:0] mode;
  logic cmpHit;
  logic watchHit;
  logic [15:0] stepped;
  logic [15:0] clock_next;

  assign tick = ce && (cnt_reg == LAST);
  assign mode = clockState[1:0];
  assign cmpHit = tick && mode == vis_pkg::MODE_COMPARE
    && clockState[15:vis_pkg::COMPARE_LSB] == compareWord[15:vis_pkg::COMPARE_LSB]; // see RULE16
  assign watchHit = tick && mode == vis_pkg::MODE_WATCH && !lineSync_reg; // see RULE13
  assign stepped = tick ? clockState + vis_pkg::CLOCK_STEP : clockState;
  // a start op in the firing cycle still lands, after the mode clear
  assign clock_next = ((cmpHit || watchHit) ? stepped & ~vis_pkg::MODE_FIELD : stepped)
    | ((ce && startReq) ? startAcc : 16'h0000); // see RULE14 see RULE17

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      lineMeta_reg <= 1'b1;
      lineSync_reg <= 1'b1;
    end else if (ce) begin
      cnt_reg <= (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
      lineMeta_reg <= serialPin;
      lineSync_reg <= lineMeta_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clockState <= vis_pkg::RESET_WORD;
      captureWord <= vis_pkg::RESET_WORD;
      fire <= 1'b0;
    end else if (ce) begin
      clockState <= clock_next;
      fire <= cmpHit || watchHit;
      if (watchHit) captureWord <= clockState; // see RULE14
      else if (cmpHit) captureWord <= {15'h0000, lineSync_reg}; // see RULE16
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // a start op in the firing cycle may set the mode again, so it is left out here
  AST_WATCH_FIRE: assert property ( // see RULE14
    watchHit && !startReq |=> fire && clockState[1:0] == 2'h0
    && captureWord == $past(clockState))
    else $error("watch hit did not fire");
  AST_COMPARE_FIRE: assert property ( // see RULE16
    cmpHit |=> fire && captureWord[15:1] == 15'h0000)
    else $error("compare hit did not fire");
  AST_QUIET_OFF: assert property ( // see RULE13
    tick && mode == vis_pkg::MODE_OFF |=> !fire)
    else $error("timer fired while off");
endmodule : vis_timer

// >>> shared/vis_pkg.sv
// vis_pkg: constants, op codes and helpers of the vectored interrupt system.
// assumes one 125 MHz clock and an AXI4-Lite master reaching the registers.
// bit naming: word bit n counts from the msb and is index 15-n, so bit 0 (disable) is index 15.
// Contract
// RULE1 - fifteen channels; word bit 15 highest priority, bit 1 lowest, bit 0 no channel
// RULE2 - active mask word: a one lets that channel interrupt
// RULE3 - pending word holds outstanding requests; word bit 0 carries none
// RULE4 - fifteen-entry vector table, first entry highest channel, last entry lowest
// RULE5 - on fetch with wakeup word positive, interrupt if (wakeup|pending)&active nonzero
// RULE6 - if zero, pending gets wakeup|pending, wakeup word cleared, instruction restarts
// RULE7 - taking: save PC, set disable bit, clear channel bit, load PC from vector
// RULE8 - requesters only OR channel bits into wakeup or pending words
// RULE9 - memory parity error triggers the highest-priority channel
// RULE10 - disable op sets disable bit so new wakeups are ignored
// RULE11 - enable op clears disable bit and ORs pending word into wakeup word
// RULE12 - return op clears disable bit, ORs pending in, restores saved PC
// RULE13 - watch mode samples line each 38 us; spacing interrupts on timer mask
// RULE14 - watch interrupt copies clock/state into capture word and clears mode bits
// RULE15 - software uses watch mode for start bit, compare mode for bit centres
// RULE16 - compare mode: each 38 us, upper ten bits equal compare word interrupts, clears mode
// RULE17 - start-timer op ORs accumulator into clock/state; low two bits pick mode
// RULE18 - among enabled requests the highest-numbered word bit is serviced
package vis_pkg;
  localparam logic [7:0] ADDR_NEW_WAKEUP = 8'h00;
  localparam logic [7:0] ADDR_PENDING = 8'h04;
  localparam logic [7:0] ADDR_ACTIVE = 8'h08;
  localparam logic [7:0] ADDR_SAVED_PC = 8'h0C;
  localparam logic [7:0] ADDR_TIMER_MASK = 8'h10;
  localparam logic [7:0] ADDR_TIMER_COMPARE = 8'h14;
  localparam logic [7:0] ADDR_TIMER_CAPTURE = 8'h18;
  localparam logic [7:0] ADDR_CLOCK_STATE = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;
  localparam logic [1:0] VEC_PAGE = 2'h1;
  localparam logic [3:0] VEC_HOLE = 4'hF;
  localparam int NUM_CHANNELS = 15;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [15:0] DISABLE_MASK = 16'h8000;
  localparam logic [15:0] CHANNEL_BITS = 16'h7FFF;
  localparam logic [15:0] PARITY_MASK = 16'h0001;
  localparam int TICK_NS = 38000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam logic [15:0] CLOCK_STEP = 16'h0040;
  localparam logic [15:0] MODE_FIELD = 16'h0003;
  localparam int COMPARE_LSB = 6;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_COMPARE = 2'h1;
  localparam logic [1:0] MODE_WATCH = 2'h3;
  localparam int EV_TAKEN = 0;
  localparam int EV_TIMER = 1;
  localparam int EV_PARITY = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {OP_DISABLE, OP_ENABLE, OP_RETURN, OP_START_TIMER} vis_op_t;

  // lowest index is the highest-priority channel
  function automatic logic [3:0] vis_pick(input logic [15:0] m);
    vis_pick = 4'h0;
    for (int i = NUM_CHANNELS - 1; i >= 0; i--) begin
      if (m[i]) vis_pick = 4'(i);
    end
  endfunction : vis_pick

  function automatic logic [15:0] vis_merge(input logic [15:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
    vis_merge = old;
    if (strb[0]) vis_merge[7:0] = data[7:0];
    if (strb[1]) vis_merge[15:8] = data[15:8];
  endfunction : vis_merge

  function automatic logic vis_is_vec(input logic [7:0] a);
    vis_is_vec = (a[7:6] == VEC_PAGE) && (a[5:2] != VEC_HOLE) && (a[1:0] == 2'h0);
  endfunction : vis_is_vec

  function automatic logic vis_mapped(input logic [7:0] a);
    vis_mapped = vis_is_vec(a) || (a <= ADDR_IRQ_MASK && a[1:0] == 2'h0);
  endfunction : vis_mapped
endpackage : vis_pkg

// >>> tb/vis_core_tb.sv
// vis_core_tb: self-checking bench for the vectored interrupt system.
// assumes vis_partner plays the program side; the AXI4-Lite master lives here.
`timescale 1ns/1ps
module vis_core_tb;
  localparam int TICK = 20;
  logic clk, rst_n, ce, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, fetchReq, opReq, parityErr, serialPin;
  logic fetchDone, fetchTake, fetchRestart, pcLoad, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rdw, seed;
  logic [3:0] wstrb, seen;
  logic [1:0] bresp, rresp, resp;
  logic [15:0] fetchPc, opAcc, pcOut, npc, wakeM, pendM, actM, pc, tm, cs;
  logic [15:0] vec [15];
  vis_pkg::vis_op_t opSel;
  int failures, compares, ch;

  vis_core #(.TICK(TICK)) dut (.clk, .rst_n, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .fetchReq, .fetchPc, .opReq, .opSel, .opAcc, .parityErr, .serialPin,
    .fetchDone, .fetchTake, .fetchRestart, .pcLoad, .pcOut, .irq);
  vis_partner p (.clk, .fetchReq, .fetchPc, .opReq, .opSel, .opAcc, .parityErr, .serialPin,
    .fetchDone, .fetchTake, .fetchRestart, .pcLoad, .pcOut);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic int pick(input logic [15:0] m);
    for (int i = 0; i < 15; i++) if (m[i]) return i;
    return -1;
  endfunction : pick

  task automatic chk(input logic [15:0] seenV, input logic [15:0] expV);
    compares++;
    if (seenV !== expV) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seenV, expV);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic guard(inout int n);
    n++;
    if (n > 300) begin
      failures++;
      tally_and_finish();
    end
  endtask : guard

  task automatic axw(input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      guard(n);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : axw

  task automatic axr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      guard(n);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        rdw = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : axr

  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    axr(a);
    chk(rdw[15:0], e);
  endtask : rchk

  task automatic op(input vis_pkg::vis_op_t s, input logic [15:0] acc);
    p.instr(1'b0, 16'h0000, s, acc, seen, npc);
  endtask : op

  // the bench mirrors both words so every fetch outcome is predicted independently
  task automatic step(input logic [15:0] pcv);
    logic [15:0] m;
    m = (wakeM | pendM) & actM & 16'h7FFF;
    ch = pick(m);
    p.instr(1'b1, pcv, vis_pkg::OP_DISABLE, 16'h0000, seen, npc);
    if (wakeM == 16'h0000 || wakeM[15]) begin
      chk(16'(seen), 16'h0008);
    end else if (m != 16'h0000) begin
      chk(16'(seen), 16'h000D);
      chk(npc, vec[ch]);
      wakeM = (wakeM | 16'h8000) & ~(16'h0001 << ch);
      pendM = pendM & ~(16'h0001 << ch);
      rchk(vis_pkg::ADDR_SAVED_PC, pcv);
    end else begin
      chk(16'(seen), 16'h000A);
      pendM = pendM | wakeM;
      wakeM = 16'h0000;
    end
    rchk(vis_pkg::ADDR_NEW_WAKEUP, wakeM);
    rchk(vis_pkg::ADDR_PENDING, pendM);
  endtask : step

  task automatic ret(input logic [15:0] pcv);
    op(vis_pkg::OP_RETURN, 16'h0000);
    chk(16'(seen), 16'h0001);
    chk(npc, pcv);
    wakeM = (wakeM & 16'h7FFF) | pendM;
    rchk(vis_pkg::ADDR_NEW_WAKEUP, wakeM);
  endtask : ret

  task automatic wait_fire();
    int n;
    n = 0;
    do begin
      axr(vis_pkg::ADDR_IRQ_STATUS);
      guard(n);
    end while (rdw[1] !== 1'b1);
  endtask : wait_fire

  initial begin
    #(8 * 40000);
    failures++;
    tally_and_finish();
  end

  initial begin
    seed = 32'h00000017;
    failures = 0;
    compares = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    wakeM = 16'h0000;
    pendM = 16'h0000;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rchk(vis_pkg::ADDR_ACTIVE, 16'h0000);
    axr(8'h28);
    chk(16'(resp), 16'(vis_pkg::RESP_SLVERR));
    chk(rdw[15:0], 16'h0000);
    axw(8'h28, 16'hFFFF);
    chk(16'(resp), 16'(vis_pkg::RESP_SLVERR));
    axw(vis_pkg::ADDR_TIMER_CAPTURE, 16'hFFFF);
    rchk(vis_pkg::ADDR_TIMER_CAPTURE, 16'h0000);
    for (int i = 0; i < 15; i++) begin
      vec[i] = 16'(xs());
      axw(8'(64 + 4 * i), vec[i]);
    end
    for (int i = 0; i < 15; i++) rchk(8'(64 + 4 * i), vec[i]);
    for (int k = 0; k < 14; k++) begin
      actM = (k == 0) ? 16'h7FFF : (k == 1) ? 16'h0000 : 16'(xs()) & 16'h7FFF;
      axw(vis_pkg::ADDR_ACTIVE, actM);
      tm = 16'(xs()) & 16'(xs()) & 16'h7FFF;
      axw(vis_pkg::ADDR_PENDING, tm);
      pendM = pendM | tm;
      tm = (k == 0) ? 16'h7FFF : 16'(xs()) & 16'(xs()) & 16'h7FFF;
      axw(vis_pkg::ADDR_NEW_WAKEUP, tm);
      wakeM = wakeM | tm;
      pc = 16'(xs());
      step(pc);
      if (wakeM[15]) ret(pc);
    end
    op(vis_pkg::OP_DISABLE, 16'h0000);
    wakeM = wakeM | 16'h8000;
    axw(vis_pkg::ADDR_NEW_WAKEUP, 16'h4000);
    wakeM = wakeM | 16'h4000;
    actM = 16'h7FFF;
    axw(vis_pkg::ADDR_ACTIVE, actM);
    step(16'h1234);
    axw(vis_pkg::ADDR_PENDING, 16'h0004);
    pendM = pendM | 16'h0004;
    op(vis_pkg::OP_ENABLE, 16'h0000);
    wakeM = (wakeM & 16'h7FFF) | pendM;
    rchk(vis_pkg::ADDR_NEW_WAKEUP, wakeM);
    step(16'h2345);
    ret(16'h2345);
    axw(vis_pkg::ADDR_IRQ_STATUS, 16'h0007);
    p.parity();
    rchk(vis_pkg::ADDR_NEW_WAKEUP, wakeM | 16'h0001);
    rchk(vis_pkg::ADDR_IRQ_STATUS, 16'h0004);
    axw(vis_pkg::ADDR_IRQ_MASK, 16'h0003);
    @(posedge clk);
    chk(16'(irq), 16'h0000);
    axw(vis_pkg::ADDR_IRQ_MASK, 16'h0004);
    @(posedge clk);
    chk(16'(irq), 16'h0001);
    axw(vis_pkg::ADDR_IRQ_STATUS, 16'h0007);
    @(posedge clk);
    chk(16'(irq), 16'h0000);
    // line watch first, then compare timing, as a serial receiver would
    tm = (16'(xs()) & 16'h7FFE) | 16'h0100;
    axw(vis_pkg::ADDR_TIMER_MASK, tm);
    op(vis_pkg::OP_START_TIMER, 16'h0003);
    // let a few ticks pass on a marking line: watch mode must stay armed
    repeat (2 * TICK) @(posedge clk);
    axr(vis_pkg::ADDR_CLOCK_STATE);
    chk(16'(rdw[1:0]), 16'h0003);
    p.line(1'b0);
    wait_fire();
    axr(vis_pkg::ADDR_CLOCK_STATE);
    chk(16'(rdw[1:0]), 16'h0000);
    axr(vis_pkg::ADDR_TIMER_CAPTURE);
    chk(16'(rdw[1:0]), 16'h0003);
    axr(vis_pkg::ADDR_NEW_WAKEUP);
    chk(rdw[15:0] & tm, tm);
    p.line(1'b1);
    axw(vis_pkg::ADDR_IRQ_STATUS, 16'h0007);
    axr(vis_pkg::ADDR_CLOCK_STATE);
    cs = rdw[15:0];
    axw(vis_pkg::ADDR_TIMER_COMPARE, (cs + 16'h0100) & 16'hFFC0);
    op(vis_pkg::OP_START_TIMER, 16'h0001);
    wait_fire();
    axr(vis_pkg::ADDR_CLOCK_STATE);
    chk(16'(rdw[1:0]), 16'h0000);
    rchk(vis_pkg::ADDR_TIMER_CAPTURE, 16'h0001);
    tally_and_finish();
  end
endmodule : vis_core_tb

// >>> tb/vis_partner.sv
// vis_partner: behavioural program and device side facing vis_core.
// assumes the core's clock; the bench calls one task at a time.
`timescale 1ns/1ps
module vis_partner (
  input wire logic clk,
  output logic fetchReq,
  output logic [15:0] fetchPc,
  output logic opReq,
  output vis_pkg::vis_op_t opSel,
  output logic [15:0] opAcc,
  output logic parityErr,
  output logic serialPin,
  input wire logic fetchDone,
  input wire logic fetchTake,
  input wire logic fetchRestart,
  input wire logic pcLoad,
  input wire logic [15:0] pcOut
);
  initial begin
    fetchReq = 1'b0;
    fetchPc = 16'h0000;
    opReq = 1'b0;
    opSel = vis_pkg::OP_DISABLE;
    opAcc = 16'h0000;
    parityErr = 1'b0;
    serialPin = 1'b1;
  end

  // one fetch or op; fetchPc and opAcc show inverted data once released so stale values never match
  task automatic instr(input logic isFetch, input logic [15:0] pcv, input vis_pkg::vis_op_t sel,
                       input logic [15:0] acc, output logic [3:0] seen, output logic [15:0] npc);
    @(posedge clk);
    fetchReq <= isFetch;
    opReq <= !isFetch;
    fetchPc <= pcv;
    opSel <= sel;
    opAcc <= acc;
    @(posedge clk);
    fetchReq <= 1'b0;
    opReq <= 1'b0;
    fetchPc <= ~pcv;
    opAcc <= ~acc;
    @(posedge clk);
    seen = {fetchDone, fetchTake, fetchRestart, pcLoad};
    npc = pcOut;
  endtask : instr

  // a request is posted as one pulse, never as an overwrite of the words
  task automatic parity();
    @(posedge clk);
    parityErr <= 1'b1;
    @(posedge clk);
    parityErr <= 1'b0;
  endtask : parity

  task automatic line(input logic v);
    @(posedge clk);
    serialPin <= v;
  endtask : line
endmodule : vis_partner
